// >>> rtl/pnpcfg_pkg.sv
/*
 * Constants and types of the configuration port block.
 * Assumes one 250 MHz clock; users write pnpcfg_pkg::name.
 */
package pnpcfg_pkg;

    // ------------------------------------------------------------------
    // Clock and power-up timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned POR_BLOCK_US   = 500;
    // MHz times microseconds: exact whole cycles
    localparam int unsigned POR_BLOCK_CYC  = POR_BLOCK_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Configuration port addresses and keys
    // ------------------------------------------------------------------
    localparam logic [15:0] CFG_BASE_STRAP0 = 16'h03F0;
    localparam logic [15:0] CFG_BASE_STRAP1 = 16'h0370;
    localparam logic [15:0] DATA_PORT_OFS   = 16'h0001;
    localparam logic [7:0]  KEY_ENTER       = 8'h55;
    localparam logic [7:0]  KEY_EXIT        = 8'hAA;

    // ------------------------------------------------------------------
    // Global register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CFG_CTRL    = 8'h02;
    localparam logic [7:0] IDX_LDN         = 8'h07;
    localparam logic [7:0] IDX_DEV_ID      = 8'h20;
    localparam logic [7:0] IDX_DEV_REV     = 8'h21;
    localparam logic [7:0] IDX_PWR_CTRL    = 8'h22;
    localparam logic [7:0] IDX_BASE_LOW    = 8'h26;
    localparam logic [7:0] IDX_BASE_HIGH   = 8'h27;
    localparam logic [7:0] IDX_LD_FIRST    = 8'h30;
    localparam int unsigned SOFT_RST_BIT   = 0;

    // ------------------------------------------------------------------
    // Per logical device register indices
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SLOTS      = 8;
    localparam logic [7:0] IDX_ACTIVATE    = 8'h30;
    localparam logic [7:0] IDX_BASE0_HI    = 8'h60;
    localparam logic [7:0] IDX_BASE0_LO    = 8'h61;
    localparam logic [7:0] IDX_BASE1_HI    = 8'h62;
    localparam logic [7:0] IDX_BASE1_LO    = 8'h63;
    localparam logic [7:0] IDX_IRQ_SEL     = 8'h70;
    localparam logic [7:0] IDX_DMA_SEL     = 8'h74;
    localparam logic [7:0] IDX_MODE        = 8'hF0;
    localparam logic [2:0] SLOT_ACTIVATE   = 3'h0;
    localparam logic [2:0] SLOT_MODE       = 3'h7;
    localparam int unsigned ACTIVATE_BIT   = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LDN         = 8'h00;
    localparam logic [7:0] RST_PWR_CTRL    = 8'h00;
    localparam logic [7:0] RST_LD_REG      = 8'h00;
    localparam logic [7:0] RST_INDEX       = 8'h00;
    localparam logic [7:0] RST_RD_DATA     = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        PNPCFG_RUN    = 1'b0,
        PNPCFG_CONFIG = 1'b1
    } pnpcfg_state_t;

    // One host I/O cycle as seen on the ISA side
    typedef struct packed {
        logic [15:0] addr;
        logic        aen;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } pnpcfg_bus_req_t;

endpackage

// >>> rtl/pnpcfg_strap_latch.sv
/*
 * Catches the base-select strap as reset releases.
 * Assumes this chip does not drive the strap pin under reset.
 */
`timescale 1ns/1ns
module pnpcfg_strap_latch (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_any,
    // Strap level and result
    input  wire logic i_strap,
    output logic      o_strap_r,
    output logic      o_load_r
);

    logic rst_d_r;

    // ------------------------------------------------------------------
    // Release detect: reset seen last cycle, gone now
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        rst_d_r <= i_rst_any;
    end

    // Sampled at release so no input feeds the reset branch
    always_ff @(posedge i_mclk) begin
        if (i_rst_any) begin
            o_strap_r <= 1'b0;
            o_load_r  <= 1'b0;
        end else begin
            o_load_r <= rst_d_r;
            if (rst_d_r) begin
                o_strap_r <= i_strap;
            end
        end
    end

endmodule

// >>> rtl/pnpcfg_por_block.sv
/*
 * Holds off host accesses for a fixed count after power-on.
 * Assumes i_por is a synchronous level.
 */
`timescale 1ns/1ns
module pnpcfg_por_block #(
    parameter int unsigned CYCLES = 125000,
    parameter int unsigned CW     = 17
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_por,
    // Hold-off flag
    output logic      o_block_r
);

    logic [CW-1:0] cnt_r;

    // ------------------------------------------------------------------
    // Counts from power-on release; hard reset does not restart it
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_por) begin
            cnt_r     <= CW'(CYCLES);
            o_block_r <= 1'b1;
        end else begin
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - CW'(1);
            end
            o_block_r <= (cnt_r > CW'(1));
        end
    end

endmodule

// >>> rtl/pnpcfg_top.sv
/*
 * Configuration port: run and configuration states, key entry and exit,
 * index and data ports, config registers, relocatable port base.
 * Assumes ISA cycles synchronous to i_mclk, one-cycle write strobes.
 */
// Overview of operation
// - Reset enters run state, devices disabled
// - Strap sampled at reset release
// - Strap 0 gives 03F0, 1 gives 0370
// - Base registers override strap when written
// - No decode while AEN is high
// - Index and data ports only in config
// - Two 55h writes enter configuration
// - AAh write returns to run
// - Index at base, data at base+1
// - Index 07h then data selects device
// - Index selects register, data port reaches it
// - Global indices ignore device selection
// - Two states, run accepts key except during power-on hold-off
// - Control bit 0 soft resets registers
// - Host blocked 500us after power-on
// - Strap pin later drives serial RTS
`timescale 1ns/1ns
module pnpcfg_top #(
    parameter int unsigned NUM_LD      = 10,
    parameter int unsigned BLOCK_CYC   = pnpcfg_pkg::POR_BLOCK_CYC,
    parameter int unsigned BLOCK_CW    = 17,
    parameter logic [7:0]  DEV_ID      = 8'h5A,  // Arbitrary identity value
    parameter logic [7:0]  DEV_REV     = 8'h01   // Arbitrary identity value
) (
    // Clock and resets
    input  wire logic                        i_mclk,
    input  wire logic                        i_srst,
    input  wire logic                        i_vcc_por,
    // Host I/O cycle
    input  wire pnpcfg_pkg::pnpcfg_bus_req_t i_bus,
    // Host read data
    output logic [7:0]                       o_rd_data,
    output logic                             o_rd_drive_n,
    // Shared strap and serial request-to-send pin
    input  wire logic                        i_strap_pin,
    output logic                             o_strap_pin,
    output logic                             o_strap_oe_n,
    input  wire logic                        i_serial1_request_to_send,
    // Configuration state seen by the rest of the chip
    output logic                             o_config_mode,
    output logic [7:0]                       o_logical_dev,
    output logic [NUM_LD-1:0]                o_ld_active,
    output logic [7:0]                       o_power_ctrl,
    output logic [15:0]                      o_config_base,
    output logic                             o_bus_blocked
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pnpcfg_pkg::pnpcfg_state_t state_r;
    logic                      rst_any;
    logic                      key_half_r;
    logic [7:0]                index_r;
    logic [7:0]                ldn_r;
    logic [7:0]                pwr_r;
    logic [7:0]                base_lo_r;
    logic [7:0]                base_hi_r;
    logic [7:0]                ld_regs_r [NUM_LD][pnpcfg_pkg::NUM_SLOTS];
    logic                      strap_val;
    logic                      strap_load;
    logic                      blocked;
    logic [15:0]               base;
    logic                      bus_ok;
    logic                      hit_cfg;
    logic                      hit_data;
    logic                      wr_cfg;
    logic                      wr_data;
    logic                      rd_data;
    logic                      soft_rst;
    logic                      ld_ok;
    logic [2:0]                slot;
    logic [3:0]                slot_code;
    logic                      slot_ok;
    logic [7:0]                rd_nxt;

    assign rst_any = i_srst | i_vcc_por;

    // ------------------------------------------------------------------
    // Slot lookup for per logical device indices
    // ------------------------------------------------------------------
    function automatic logic [3:0] slot_of(input logic [7:0] idx);
        logic [3:0] s;
        s = 4'h0;
        unique case (idx)
            pnpcfg_pkg::IDX_ACTIVATE: s = {1'b1, pnpcfg_pkg::SLOT_ACTIVATE};
            pnpcfg_pkg::IDX_BASE0_HI: s = 4'h9;
            pnpcfg_pkg::IDX_BASE0_LO: s = 4'hA;
            pnpcfg_pkg::IDX_BASE1_HI: s = 4'hB;
            pnpcfg_pkg::IDX_BASE1_LO: s = 4'hC;
            pnpcfg_pkg::IDX_IRQ_SEL:  s = 4'hD;
            pnpcfg_pkg::IDX_DMA_SEL:  s = 4'hE;
            pnpcfg_pkg::IDX_MODE:     s = {1'b1, pnpcfg_pkg::SLOT_MODE};
            default:                  s = 4'h0;
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Helpers: strap capture and power-on hold-off
    // ------------------------------------------------------------------
    pnpcfg_strap_latch u_strap (
        .i_mclk    (i_mclk),
        .i_rst_any (rst_any),
        .i_strap   (i_strap_pin),
        .o_strap_r (strap_val),
        .o_load_r  (strap_load)
    );

    pnpcfg_por_block #(
        .CYCLES (BLOCK_CYC),
        .CW     (BLOCK_CW)
    ) u_block (
        .i_mclk    (i_mclk),
        .i_por     (i_vcc_por),
        .o_block_r (blocked)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // DMA cycles carry AEN high and never hit
    assign base     = {base_hi_r, base_lo_r};
    assign bus_ok   = !i_bus.aen && !blocked && !rst_any;
    assign hit_cfg  = bus_ok && (i_bus.addr == base);
    assign hit_data = bus_ok && (state_r == pnpcfg_pkg::PNPCFG_CONFIG)
                      && (i_bus.addr == base + pnpcfg_pkg::DATA_PORT_OFS);
    assign wr_cfg   = hit_cfg && i_bus.wr;
    assign wr_data  = hit_data && i_bus.wr;
    assign rd_data  = hit_data && i_bus.rd;

    // Write-only bit: acts once, not stored
    assign soft_rst = wr_data && (index_r == pnpcfg_pkg::IDX_CFG_CTRL)
                      && i_bus.wdata[pnpcfg_pkg::SOFT_RST_BIT];

    // Per-device access needs a real device and known index
    assign ld_ok    = (ldn_r < 8'(NUM_LD));
    assign slot_code = slot_of(index_r);
    assign slot      = slot_code[2:0];
    assign slot_ok   = slot_code[3] && ld_ok;

    // ------------------------------------------------------------------
    // Run and configuration state
    // ------------------------------------------------------------------
    // In run every config port write is a key candidate
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            state_r    <= pnpcfg_pkg::PNPCFG_RUN;
            key_half_r <= 1'b0;
        end else if (wr_cfg) begin
            unique case (state_r)
                pnpcfg_pkg::PNPCFG_RUN: begin
                    if (i_bus.wdata == pnpcfg_pkg::KEY_ENTER) begin
                        if (key_half_r) begin
                            state_r    <= pnpcfg_pkg::PNPCFG_CONFIG;
                            key_half_r <= 1'b0;
                        end else begin
                            key_half_r <= 1'b1;
                        end
                    end else begin
                        key_half_r <= 1'b0;
                    end
                end
                pnpcfg_pkg::PNPCFG_CONFIG: begin
                    if (i_bus.wdata == pnpcfg_pkg::KEY_EXIT) begin
                        state_r <= pnpcfg_pkg::PNPCFG_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Index register
    // ------------------------------------------------------------------
    // The exit key shares the index port, so it is never kept
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            index_r <= pnpcfg_pkg::RST_INDEX;
        end else if (wr_cfg && state_r == pnpcfg_pkg::PNPCFG_CONFIG
                     && i_bus.wdata != pnpcfg_pkg::KEY_EXIT) begin
            index_r <= i_bus.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Logical device number and power control
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (rst_any || soft_rst) begin
            ldn_r <= pnpcfg_pkg::RST_LDN;
            pwr_r <= pnpcfg_pkg::RST_PWR_CTRL;
        end else if (wr_data) begin
            if (index_r == pnpcfg_pkg::IDX_LDN) begin
                ldn_r <= i_bus.wdata;
            end
            if (index_r == pnpcfg_pkg::IDX_PWR_CTRL) begin
                pwr_r <= i_bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration port base
    // ------------------------------------------------------------------
    // Soft reset keeps the base so software keeps the port
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            base_hi_r <= pnpcfg_pkg::CFG_BASE_STRAP0[15:8];
            base_lo_r <= pnpcfg_pkg::CFG_BASE_STRAP0[7:0];
        end else if (strap_load) begin
            if (strap_val) begin
                base_hi_r <= pnpcfg_pkg::CFG_BASE_STRAP1[15:8];
                base_lo_r <= pnpcfg_pkg::CFG_BASE_STRAP1[7:0];
            end else begin
                base_hi_r <= pnpcfg_pkg::CFG_BASE_STRAP0[15:8];
                base_lo_r <= pnpcfg_pkg::CFG_BASE_STRAP0[7:0];
            end
        end else if (wr_data) begin
            if (index_r == pnpcfg_pkg::IDX_BASE_LOW) begin
                base_lo_r <= i_bus.wdata;
            end
            if (index_r == pnpcfg_pkg::IDX_BASE_HIGH) begin
                base_hi_r <= i_bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per logical device registers
    // ------------------------------------------------------------------
    // Mode registers survive a soft reset
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            for (int d = 0; d < NUM_LD; d++) begin
                for (int s = 0; s < pnpcfg_pkg::NUM_SLOTS; s++) begin
                    ld_regs_r[d][s] <= pnpcfg_pkg::RST_LD_REG;
                end
            end
        end else if (soft_rst) begin
            for (int d = 0; d < NUM_LD; d++) begin
                for (int s = 0; s < pnpcfg_pkg::NUM_SLOTS; s++) begin
                    if (3'(s) != pnpcfg_pkg::SLOT_MODE) begin
                        ld_regs_r[d][s] <= pnpcfg_pkg::RST_LD_REG;
                    end
                end
            end
        end else if (wr_data && slot_ok) begin
            ld_regs_r[ldn_r[3:0]][slot] <= i_bus.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    // Global indices never look at the device number
    always_comb begin
        rd_nxt = pnpcfg_pkg::RST_RD_DATA;
        if (index_r < pnpcfg_pkg::IDX_LD_FIRST) begin
            unique case (index_r)
                pnpcfg_pkg::IDX_LDN:       rd_nxt = ldn_r;
                pnpcfg_pkg::IDX_DEV_ID:    rd_nxt = DEV_ID;
                pnpcfg_pkg::IDX_DEV_REV:   rd_nxt = DEV_REV;
                pnpcfg_pkg::IDX_PWR_CTRL:  rd_nxt = pwr_r;
                pnpcfg_pkg::IDX_BASE_LOW:  rd_nxt = base_lo_r;
                pnpcfg_pkg::IDX_BASE_HIGH: rd_nxt = base_hi_r;
                default:                   rd_nxt = pnpcfg_pkg::RST_RD_DATA;
            endcase
        end else if (slot_ok) begin
            rd_nxt = ld_regs_r[ldn_r[3:0]][slot];
        end
    end

    // ------------------------------------------------------------------
    // Host read drive
    // ------------------------------------------------------------------
    // Data follows the read strobe by one cycle
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            o_rd_data    <= pnpcfg_pkg::RST_RD_DATA;
            o_rd_drive_n <= 1'b1;
        end else begin
            o_rd_drive_n <= !rd_data;
            if (rd_data) begin
                o_rd_data <= rd_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared strap and request-to-send pin
    // ------------------------------------------------------------------
    // Released through reset so the strap can be sampled
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            o_strap_pin  <= 1'b1;
            o_strap_oe_n <= 1'b1;
        end else begin
            o_strap_pin  <= i_serial1_request_to_send;
            o_strap_oe_n <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (rst_any) begin
            o_config_mode <= 1'b0;
            o_logical_dev <= pnpcfg_pkg::RST_LDN;
            o_power_ctrl  <= pnpcfg_pkg::RST_PWR_CTRL;
            o_bus_blocked <= 1'b1;
        end else begin
            o_config_mode <= (state_r == pnpcfg_pkg::PNPCFG_CONFIG);
            o_logical_dev <= ldn_r;
            o_power_ctrl  <= pwr_r;
            o_bus_blocked <= blocked;
        end
    end

    // Base and activate bits come straight from flops
    assign o_config_base = base;

    for (genvar g = 0; g < NUM_LD; g++) begin : g_active
        assign o_ld_active[g] =
            ld_regs_r[g][pnpcfg_pkg::SLOT_ACTIVATE][pnpcfg_pkg::ACTIVATE_BIT];
    end

endmodule

// >>> verif/pnpcfg_checker.sv
/* Port-level checks of the configuration port block.
   Assumes binding to pnpcfg_top ports only. */
`timescale 1ns/1ns
module pnpcfg_checker (
    // Clock, resets, host cycle and serial request-to-send
    input wire logic                        i_mclk,
    input wire logic                        i_srst,
    input wire logic                        i_vcc_por,
    input wire pnpcfg_pkg::pnpcfg_bus_req_t i_bus,
    input wire logic                        i_serial1_request_to_send,
    // Watched outputs
    input wire logic                        o_rd_drive_n,
    input wire logic                        o_strap_pin,
    input wire logic                        o_strap_oe_n,
    input wire logic                        o_config_mode,
    input wire logic [15:0]                 o_config_base,
    input wire logic                        o_bus_blocked
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst || i_vcc_por);
    // Decode from outside; DMA cycles never hit
    wire logic hit_cfg = !i_bus.aen && i_bus.addr == o_config_base;
    wire logic hit_dat = !i_bus.aen && i_bus.addr == o_config_base + 16'h0001;
    wire logic wr_cfg  = i_bus.wr && hit_cfg && !o_bus_blocked;
    wire logic key_in  = wr_cfg && i_bus.wdata == pnpcfg_pkg::KEY_ENTER;

    a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> o_rd_drive_n && o_strap_oe_n && o_strap_pin)
        else $error("outputs not quiet in reset");
    a_aen_ignored: assert property (i_bus.aen |=> o_rd_drive_n)
        else $error("drove bus on a DMA cycle");
    a_index_silent: assert property (i_bus.rd && hit_cfg |=> o_rd_drive_n)
        else $error("index port drove");
    a_run_data_quiet: assert property (i_bus.rd && hit_dat ##1 !o_config_mode |-> o_rd_drive_n)
        else $error("data port drove in run");
    a_cfg_data_drive: assert property (i_bus.rd && hit_dat ##1 o_config_mode |-> !o_rd_drive_n)
        else $error("data port silent in config");
    a_key_enter: assert property (
        key_in ##1 !wr_cfg ##1 key_in ##1 !o_config_mode |=> o_config_mode)
        else $error("key did not enter");
    a_exit_key: assert property (
        wr_cfg && i_bus.wdata == pnpcfg_pkg::KEY_EXIT ##1 o_config_mode |=> !o_config_mode)
        else $error("exit key ignored");
    a_rts_follow: assert property (1'b1 |=> !o_strap_oe_n && o_strap_pin == $past(i_serial1_request_to_send))
        else $error("pin not carrying RTS");
    a_por_hold: assert property (disable iff (i_srst)
        $fell(i_vcc_por) |-> o_bus_blocked [*8])
        else $error("hold-off ended too early");
    c_enter: cover property ($rose(o_config_mode));
    c_exit: cover property ($fell(o_config_mode));
    c_read: cover property (!o_rd_drive_n);
endmodule

bind pnpcfg_top pnpcfg_checker u_chk (.i_mclk, .i_srst, .i_vcc_por, .i_bus, .i_serial1_request_to_send,
    .o_rd_drive_n, .o_strap_pin, .o_strap_oe_n, .o_config_mode, .o_config_base, .o_bus_blocked);

// >>> verif/pnpcfg_host_model.sv
/* ISA host: one I/O cycle at a time through io().
   Assumes read data returns a cycle later. */
`timescale 1ns/1ns
module pnpcfg_host_model (
    // Clock and answer
    input  wire logic [7:0]          i_rd_data,
    input  wire logic                i_mclk,
    input  wire logic                i_rd_drive_n,
    // Request
    output pnpcfg_pkg::pnpcfg_bus_req_t o_bus
);
    initial o_bus = '0;
    // Data flips after the cycle: stale bytes never look valid
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, input logic aen,
                      output logic [7:0] q, output logic dn);
        @(posedge i_mclk);
        o_bus <= '{a, aen, w, !w, d};
        @(posedge i_mclk);
        o_bus.wr <= 1'b0;
        o_bus.rd <= 1'b0;
        o_bus.wdata <= ~d;
        #1;
        q = i_rd_data;
        dn = i_rd_drive_n;
    endtask
endmodule

// >>> verif/test_pnpcfg_top.sv
/* Self-checking bench with a model of the configuration space.
   Assumes a short hold-off and the host model. */
`timescale 1ns/1ns
module test_pnpcfg_top;
    logic clk = 1'b0, srst = 1'b1, por = 1'b1, strap = 1'b0, rts = 1'b0, drv_n, spin, soe_n, mode, blk;
    logic [7:0] rd_data, ldev, pwr, n, d;
    logic [9:0] ld_act;
    logic [15:0] cbase, cp, dp;
    pnpcfg_pkg::pnpcfg_bus_req_t bus;
    integer seed = 32'ha9db, err_total = 0, compares = 0, m_cfg, m_key, m_idx, m_ldn, m_pwr, m_base, m_blk;
    integer m_reg [int];
    assign cp = 16'(m_base);
    assign dp = cp + 16'h0001;
    // Shared pin: strap level until the chip drives it
    wire logic pin = soe_n ? strap : spin;
    always #2 clk = ~clk;
    always @(posedge clk) rts <= 1'($random(seed));
    pnpcfg_top #(.BLOCK_CYC(20)) dut (.i_mclk(clk), .i_srst(srst), .i_vcc_por(por), .i_bus(bus),
        .o_rd_data(rd_data), .o_rd_drive_n(drv_n), .i_strap_pin(pin), .o_strap_pin(spin),
        .o_strap_oe_n(soe_n), .i_serial1_request_to_send(rts), .o_config_mode(mode),
        .o_logical_dev(ldev), .o_ld_active(ld_act), .o_power_ctrl(pwr), .o_config_base(cbase),
        .o_bus_blocked(blk));
    pnpcfg_host_model host (.i_rd_data(rd_data), .i_mclk(clk), .i_rd_drive_n(drv_n), .o_bus(bus));
    task automatic chk_out(input string s, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_rd(input logic en, input logic [7:0] e, input logic [7:0] q, input logic dn);
        chk_out("read drive", 16'(!en), 16'(dn));
        if (en) chk_out("read data", 16'(e), 16'(q));
    endtask
    task automatic chk_mode;
        repeat (2) @(posedge clk);
        #1 chk_out("config mode", 16'(m_cfg), 16'(mode));
    endtask
    function automatic logic [7:0] m_read;
        case (m_idx)
            8'h07: return 8'(m_ldn);
            8'h20: return 8'h5A;
            8'h22: return 8'(m_pwr);
            8'h26: return cp[7:0];
            default: return 8'(m_reg.exists(m_ldn * 256 + m_idx) ? m_reg[m_ldn * 256 + m_idx] : 0);
        endcase
    endfunction
    task automatic m_write(input logic [15:0] a, input logic [7:0] v);
        if (a == cp && !m_cfg) begin
            m_cfg = (v == 8'h55) && m_key;
            m_key = (v == 8'h55) && !m_key;
        end else if (a == cp) begin
            if (v == 8'hAA) m_cfg = 0; else m_idx = v;
        end else if (a == dp && m_cfg) begin
            case (m_idx)
                8'h02: if (v[0]) begin m_ldn = 0; m_pwr = 0; foreach (m_reg[k]) if (k % 256 != 8'hF0) m_reg[k] = 0; end
                8'h07: m_ldn = v;
                8'h22: m_pwr = v;
                8'h26: m_base[7:0] = v;
                default: if (m_ldn < 10 && m_idx >= 8'h30) m_reg[m_ldn * 256 + m_idx] = v;
            endcase
        end
    endtask
    task automatic op(input logic w, input logic [15:0] a, input logic [7:0] v, input logic aen = 1'b0);
        logic [7:0] q, e;
        logic dn, en;
        en = !w && !aen && !m_blk && m_cfg && a == dp;
        e = m_read();
        host.io(w, a, v, aen, q, dn);
        if (!w) chk_rd(en, e, q, dn);
        else if (!aen && !m_blk) m_write(a, v);
    endtask
    task automatic do_reset(input logic p);
        @(posedge clk);
        strap <= 1'($random(seed));
        srst <= 1'b1;
        por <= p;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        por <= 1'b0;
        repeat (2) @(posedge clk);
        {m_cfg, m_key, m_idx, m_ldn, m_pwr, m_blk} = {5'd0, 32'(p)};
        m_reg.delete();
        m_base = strap ? 16'h0370 : 16'h03F0;
        #1 chk_out("config base", cp, cbase);
        chk_out("active devices", 16'h0000, 16'(ld_act));
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset(1'b1);
        op(1, cp, 8'h55); op(1, cp, 8'h55); chk_mode;
        repeat (20) @(posedge clk);
        m_blk = 0;
        op(0, dp, 8'h00); op(1, dp, 8'h07);
        op(1, cp, 8'h55); op(1, cp, 8'h3C); op(1, cp, 8'h55); op(1, cp, 8'h55, 1'b1); chk_mode;
        op(1, cp, 8'h55); chk_mode;
        $display("test entry done");
        op(1, cp, 8'h20); op(0, dp, 8'h00); op(0, cp, 8'h00);
        for (int i = 0; i < 3; i++) begin
            n = 8'($unsigned($random(seed)) % 10);
            d = 8'($random(seed));
            op(1, cp, 8'h22); op(1, dp, d);
            op(1, cp, 8'h07); op(1, dp, n);
            op(1, cp, 8'h30); op(1, dp, d); op(0, dp, 8'h00);
            op(1, cp, 8'h60); op(1, dp, ~d); op(0, dp, 8'h00);
            chk_out("device active", 16'(d[0]), 16'(ld_act[n]));
            chk_out("logical device", 16'(n), 16'(ldev));
            chk_out("power control", 16'(d), 16'(pwr));
        end
        op(1, cp, 8'h26); op(1, dp, 8'h10); op(1, cp, 8'h26); op(0, dp, 8'h00);
        op(1, cp, 8'h02); op(1, dp, 8'h01); op(1, cp, 8'h60); op(0, dp, 8'h00);
        op(1, cp, 8'hAA); chk_mode; op(0, dp, 8'h00);
        $display("test registers done");
        do_reset(1'b0);
        op(1, cp, 8'h55); op(1, cp, 8'h55); chk_mode;
        $display("test hard reset done");
        tally_and_finish;
    end
    // Watchdog: the sequence needs about 150 cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end
endmodule
